// ### fep_consts.vh
// Offsets, field positions and reset values of the fault event pending logic
`ifndef FEP_CONSTS_VH
`define FEP_CONSTS_VH

// Register byte offsets on the register bus
`define FEP_OFF_STATUS    12'h034
`define FEP_OFF_CTL       12'h038
`define FEP_OFF_DATA      12'h03C
`define FEP_OFF_ADDR      12'h040
`define FEP_OFF_UADDR     12'h044
`define FEP_OFF_IRQ_STS   12'h048
`define FEP_OFF_IRQ_EN    12'h04C

// Control register fields
`define FEP_CTL_MASK_BIT  31
`define FEP_CTL_PEND_BIT  30
`define FEP_CTL_KEEP_MSB  29
`define FEP_CTL_MASK_RST  1'h1
`define FEP_CTL_PEND_RST  1'h0
`define FEP_CTL_KEEP_RST  30'h00000000

// Fault status fields: primary flag alone, then advanced..overflow contiguous
`define FEP_STS_PPF_BIT   1
`define FEP_STS_W1C_LSB   3
`define FEP_STS_W1C_W     5
`define FEP_NUM_REC       8

// Local interrupt status and enable
`define FEP_IRQ_W         7
`define FEP_IRQ_EN_RST    7'h00

// Register bus answers
`define FEP_RESP_OKAY     2'h0
`define FEP_RESP_SLVERR   2'h2

`endif

// ### fep_sticky_bank.v
// Bank of sticky flags, set by hardware and cleared by writing a one
`timescale 1ns/1ps
module fep_sticky_bank #(
    parameter WIDTH = 5
) (
    input  wire             sys_clk,   // Core clock
    input  wire             rstn,      // Synchronous reset, active low
    input  wire [WIDTH-1:0] set_in,    // Hardware set pulses
    input  wire [WIDTH-1:0] clr_in,    // Software clear pulses
    output wire [WIDTH-1:0] flags      // Current flag values
);

    reg [WIDTH-1:0] flag_q;

    assign flags = flag_q;

    ////////////////////////////////////////////////////////////////////////
    // One flop per flag; set beats clear so no event is lost
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_flag
            always @(posedge sys_clk) begin
                if (!rstn) begin
                    flag_q[g] <= 1'b0;
                end else if (set_in[g]) begin
                    flag_q[g] <= 1'b1;
                end else if (clr_in[g]) begin
                    flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// ### fep_msg_sender.v
// Message write launcher holding address and data until the fabric takes them
`timescale 1ns/1ps
module fep_msg_sender (
    input  wire        sys_clk,    // Core clock
    input  wire        rstn,       // Synchronous reset, active low
    input  wire        start,      // Launch one message write
    input  wire [31:0] data_in,    // Message data to send
    input  wire [31:0] addr_in,    // Message lower address
    input  wire [31:0] uaddr_in,   // Message upper address
    input  wire        msg_ready,  // Fabric accepts the write
    output reg         msg_valid,  // Write offered to the fabric
    output reg  [31:0] msg_data,   // Offered data
    output reg  [31:0] msg_addr,   // Offered lower address
    output reg  [31:0] msg_uaddr,  // Offered upper address
    output wire        busy,       // Write launched, not yet taken
    output wire        done        // Write taken this cycle
);

    assign busy = msg_valid;
    assign done = msg_valid & msg_ready;

    ////////////////////////////////////////////////////////////////////////
    // Payload is frozen at launch so later register writes cannot tear it
    always @(posedge sys_clk) begin
        if (!rstn) begin
            msg_valid <= 1'b0;
            msg_data  <= 32'h00000000;
            msg_addr  <= 32'h00000000;
            msg_uaddr <= 32'h00000000;
        end else if (start && !msg_valid) begin
            msg_valid <= 1'b1;
            msg_data  <= data_in;
            msg_addr  <= addr_in;
            msg_uaddr <= uaddr_in;
        end else if (msg_valid && msg_ready) begin
            msg_valid <= 1'b0;
        end
    end

endmodule

// ### fep_top.v
// Fault event pending logic with register bus, status flags and message launch
//
// Overview of operation
// - Pending bit 30 of the control register is read-only, resets to 0 and sets on any condition, except one arriving in the cycle the fabric takes the message.
// - In primary mode a newly recorded fault setting the primary flag is a condition.
// - In advanced mode writing log record 0 and setting the advanced flag is a condition.
// - A queue error sets the queue error flag and is a condition.
// - A bad invalidation completion sets the completion error flag and is a condition.
// - An invalidation completion time-out sets the timeout flag and is a condition.
// - A page request queue overflow sets the overflow flag and is a condition.
// - Pending stays set while the message is held undelivered.
// - The message is held while the mask bit is set or the fabric cannot take it.
// - Pending clears once the message is sent or software removes its cause.
// - Clearing the mask while a message is held sends it, then clears pending.
// - Software clearing all relevant flags before launch drops the held message and the pending bit.
// - Mask bit 31 of the control register resets to 1 and blocks sending while set.
// - With the mask clear, a condition sends a write of the data and address registers.
// - The primary flag is the OR of all fault recording valid bits.
`timescale 1ns/1ps
`include "fep_consts.vh"
module fep_top (
    input  wire        sys_clk, // Core clock, 100 MHz
    input  wire        rstn, // Synchronous reset, active low
    input  wire [11:0] s_axi_awaddr, // Write address
    input  wire        s_axi_awvalid, // Write address valid
    output wire        s_axi_awready, // Write address ready
    input  wire [31:0] s_axi_wdata, // Write data
    input  wire [3:0]  s_axi_wstrb, // Write byte strobes
    input  wire        s_axi_wvalid, // Write data valid
    output wire        s_axi_wready, // Write data ready
    output reg  [1:0]  s_axi_bresp, // Write response
    output reg         s_axi_bvalid, // Write response valid
    input  wire        s_axi_bready, // Write response ready
    input  wire [11:0] s_axi_araddr, // Read address
    input  wire        s_axi_arvalid, // Read address valid
    output wire        s_axi_arready, // Read address ready
    output reg  [31:0] s_axi_rdata, // Read data
    output reg  [1:0]  s_axi_rresp, // Read response
    output reg         s_axi_rvalid, // Read data valid
    input  wire        s_axi_rready, // Read data ready
    input  wire        adv_log_active, // High: advanced logging, low: primary
    input  wire [7:0]  rec_valid, // Valid bits of the fault recording registers
    input  wire        adv_first_evt, // Record 0 of the fault log written
    input  wire        queue_err_evt, // Invalidation queue error
    input  wire        cpl_err_evt, // Invalid invalidation completion
    input  wire        cpl_timeout_evt, // Invalidation completion time-out
    input  wire        prq_overflow_evt, // Page request queue overflow
    output wire        msg_valid, // Message write offered
    input  wire        msg_ready, // Fabric takes the write
    output wire [31:0] msg_data, // Message data
    output wire [31:0] msg_addr, // Message lower address
    output wire [31:0] msg_uaddr, // Message upper address
    output wire        irq // Level, high while an enabled event is logged
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    reg                         message_mask_bit;
    reg                         message_pending_bit;
    reg [`FEP_CTL_KEEP_MSB:0]   ctl_keep;
    reg [31:0]                  msg_data_reg;
    reg [31:2]                  msg_addr_reg;
    reg [31:0]                  msg_uaddr_reg;
    reg [`FEP_IRQ_W-1:0]        irq_en;
    reg                         ppf_q;

    // Write channel capture
    reg                         aw_got;
    reg                         w_got;
    reg [11:0]                  aw_addr_q;
    reg [31:0]                  w_data_q;
    reg [3:0]                   w_strb_q;

    wire                        wr_fire;
    wire [11:0]                 wr_addr;
    wire                        primary_pending_flag;
    wire [`FEP_STS_W1C_W-1:0]   sts_flags;
    wire [`FEP_STS_W1C_W-1:0]   sts_set;
    wire [`FEP_STS_W1C_W-1:0]   sts_clr;
    wire [`FEP_IRQ_W-1:0]       irq_sts;
    wire [`FEP_IRQ_W-1:0]       irq_set;
    wire [`FEP_IRQ_W-1:0]       irq_clr;
    wire                        advanced_pending_flag;
    wire                        queue_error_flag;
    wire                        completion_error_flag;
    wire                        completion_timeout_flag;
    wire                        page_request_overflow_flag;
    wire                        cond_primary;
    wire                        cond_adv;
    wire                        cond_any;
    wire                        causes_clear;
    wire                        send_busy;
    wire                        send_done;
    wire                        send_start;
    wire [31:0]                 sts_read;
    wire [31:0]                 ctl_read;
    wire [31:0]                 ctl_new  = merge({2'b00, ctl_keep}, w_data_q, w_strb_q);
    wire [31:0]                 addr_new = merge({msg_addr_reg, 2'b00}, w_data_q, w_strb_q);

    ////////////////////////////////////////////////////////////////////////
    // Byte-strobe merge for plain read/write registers
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, one at a time
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign wr_fire       = aw_got && w_got && !s_axi_bvalid;
    assign wr_addr       = {aw_addr_q[11:2], 2'b00};

    always @(posedge sys_clk) begin
        if (!rstn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got    <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got    <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves are held
    always @(posedge sys_clk) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FEP_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (wr_addr)
                `FEP_OFF_STATUS, `FEP_OFF_CTL, `FEP_OFF_DATA, `FEP_OFF_ADDR,
                `FEP_OFF_UADDR, `FEP_OFF_IRQ_STS, `FEP_OFF_IRQ_EN: begin
                    s_axi_bresp <= `FEP_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `FEP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain read/write registers; the pending bit is never written
    always @(posedge sys_clk) begin
        if (!rstn) begin
            message_mask_bit <= `FEP_CTL_MASK_RST;
            ctl_keep         <= `FEP_CTL_KEEP_RST;
            msg_data_reg     <= 32'h00000000;
            msg_addr_reg     <= 30'h00000000;
            msg_uaddr_reg    <= 32'h00000000;
            irq_en           <= `FEP_IRQ_EN_RST;
        end else if (wr_fire) begin
            case (wr_addr)
                `FEP_OFF_CTL: begin
                    if (w_strb_q[3]) begin
                        message_mask_bit <= w_data_q[`FEP_CTL_MASK_BIT];
                    end
                    // Kept only for readback, no effect on messaging
                    ctl_keep <= ctl_new[`FEP_CTL_KEEP_MSB:0];
                end
                `FEP_OFF_DATA: begin
                    msg_data_reg <= merge(msg_data_reg, w_data_q, w_strb_q);
                end
                `FEP_OFF_ADDR: begin
                    msg_addr_reg <= addr_new[31:2];
                end
                `FEP_OFF_UADDR: begin
                    msg_uaddr_reg <= merge(msg_uaddr_reg, w_data_q, w_strb_q);
                end
                `FEP_OFF_IRQ_EN: begin
                    if (w_strb_q[0]) begin
                        irq_en <= w_data_q[`FEP_IRQ_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault status flags and interrupt conditions
    assign primary_pending_flag = |rec_valid;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            ppf_q <= 1'b0;
        end else begin
            ppf_q <= primary_pending_flag;
        end
    end

    // Primary condition is the flag rising, not the flag level
    assign cond_primary = !adv_log_active && primary_pending_flag && !ppf_q;
    // Advanced flag only sets while clear, so later records raise nothing
    assign cond_adv     = adv_log_active && adv_first_evt && !advanced_pending_flag;
    assign sts_set = {prq_overflow_evt,
                      cpl_timeout_evt,
                      cpl_err_evt,
                      queue_err_evt,
                      cond_adv};
    assign sts_clr = (wr_fire && wr_addr == `FEP_OFF_STATUS && w_strb_q[0])
                     ? w_data_q[`FEP_STS_W1C_LSB +: `FEP_STS_W1C_W]
                     : {`FEP_STS_W1C_W{1'b0}};
    fep_sticky_bank #(.WIDTH (`FEP_STS_W1C_W)) u_status (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .set_in  (sts_set),
        .clr_in  (sts_clr),
        .flags   (sts_flags)
    );
    assign advanced_pending_flag      = sts_flags[0];
    assign queue_error_flag           = sts_flags[1];
    assign completion_error_flag      = sts_flags[2];
    assign completion_timeout_flag    = sts_flags[3];
    assign page_request_overflow_flag = sts_flags[4];
    assign cond_any = cond_primary | cond_adv | queue_err_evt | cpl_err_evt
                      | cpl_timeout_evt | prq_overflow_evt;
    // No flag of the active mode left: event serviced
    assign causes_clear = !(adv_log_active ? advanced_pending_flag : primary_pending_flag)
                          && !queue_error_flag && !completion_error_flag
                          && !completion_timeout_flag
                          && !page_request_overflow_flag;

    ////////////////////////////////////////////////////////////////////////
    // Pending state and launch; a launched write cannot be withdrawn
    assign send_start = message_pending_bit && !message_mask_bit
                        && !send_busy && !causes_clear;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            message_pending_bit <= `FEP_CTL_PEND_RST;
        end else if (send_done) begin
            message_pending_bit <= 1'b0;
        end else if (cond_any) begin
            // Already pending: merged into the held message
            message_pending_bit <= 1'b1;
        end else if (causes_clear && !send_busy) begin
            message_pending_bit <= 1'b0;
        end else begin
            message_pending_bit <= message_pending_bit;
        end
    end

    fep_msg_sender u_sender (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .start     (send_start),
        .data_in   (msg_data_reg),
        .addr_in   ({msg_addr_reg, 2'b00}),
        .uaddr_in  (msg_uaddr_reg),
        .msg_ready (msg_ready),
        .msg_valid (msg_valid),
        .msg_data  (msg_data),
        .msg_addr  (msg_addr),
        .msg_uaddr (msg_uaddr),
        .busy      (send_busy),
        .done      (send_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Local interrupt: sticky events gated by the enable register
    assign irq_set = {send_done, prq_overflow_evt, cpl_timeout_evt, cpl_err_evt,
                      queue_err_evt, cond_adv, cond_primary};
    assign irq_clr = (wr_fire && wr_addr == `FEP_OFF_IRQ_STS && w_strb_q[0])
                     ? w_data_q[`FEP_IRQ_W-1:0] : {`FEP_IRQ_W{1'b0}};
    fep_sticky_bank #(.WIDTH (`FEP_IRQ_W)) u_irq (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .set_in  (irq_set),
        .clr_in  (irq_clr),
        .flags   (irq_sts)
    );

    assign irq = |(irq_sts & irq_en);

    ////////////////////////////////////////////////////////////////////////
    // Read channel, answer one cycle after the address is taken
    assign sts_read = {24'h000000, sts_flags, 1'b0, primary_pending_flag, 1'b0};
    assign ctl_read = {message_mask_bit, message_pending_bit, ctl_keep};
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `FEP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `FEP_RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                `FEP_OFF_STATUS:  s_axi_rdata <= sts_read;
                `FEP_OFF_CTL:     s_axi_rdata <= ctl_read;
                `FEP_OFF_DATA:    s_axi_rdata <= msg_data_reg;
                `FEP_OFF_ADDR:    s_axi_rdata <= {msg_addr_reg, 2'b00};
                `FEP_OFF_UADDR:   s_axi_rdata <= msg_uaddr_reg;
                `FEP_OFF_IRQ_STS: s_axi_rdata <= {25'h0000000, irq_sts};
                `FEP_OFF_IRQ_EN:  s_axi_rdata <= {25'h0000000, irq_en};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `FEP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ### fep_chk.sv
// Port checker for the fault event pending logic
`timescale 1ns/1ps
module fep_chk (
    input wire        sys_clk,       // Clock
    input wire        rstn,          // Reset
    input wire        s_axi_awready, // AW ready
    input wire        s_axi_wready,  // W ready
    input wire        s_axi_bvalid,  // B valid
    input wire        s_axi_bready,  // B ready
    input wire        s_axi_arvalid, // AR valid
    input wire        s_axi_arready, // AR ready
    input wire        s_axi_rvalid,  // R valid
    input wire        msg_valid,     // Offer
    input wire        msg_ready,     // Take
    input wire [31:0] msg_data,      // Data
    input wire [31:0] msg_addr,      // Address
    input wire        irq            // Interrupt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // Offer stalled by the fabric, offer taken
    sequence s_wait; msg_valid && !msg_ready; endsequence
    sequence s_take; msg_valid && msg_ready; endsequence
    property p_hold; s_wait |=> msg_valid && $stable(msg_data) && $stable(msg_addr); endproperty
    a_hold: assert property (p_hold) else $error("held offer changed");
    property p_align; msg_valid |-> msg_addr[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("address unaligned");
    // A retake needs a fresh condition
    property p_once; s_take |=> !msg_valid [*2]; endproperty
    a_once: assert property (p_once) else $error("extra message");
    property p_quiet; $rose(rstn) |-> !msg_valid && !irq; endproperty
    a_quiet: assert property (p_quiet) else $error("active after reset");
    ////////////////////////////////////////////////////////////////////////////////
    // Register bus handshakes
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken while busy");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wblk: assert property (p_wblk) else $error("write taken while busy");
endmodule

// ### fep_fabric.sv
// Model of the interrupt fabric taking message writes
`timescale 1ns/1ps
module fep_fabric (
    input  wire        sys_clk,   // Clock
    input  wire        rstn,      // Reset
    input  wire        msg_valid, // Offer
    input  wire [31:0] msg_data,  // Data
    input  wire [31:0] msg_addr,  // Address
    input  wire [3:0]  stall,     // Cycles before taking
    output reg         msg_ready, // Take
    output reg  [7:0]  n_got,     // Writes taken
    output reg  [31:0] got_data,  // Last data
    output reg  [31:0] got_addr   // Last address
);
    reg [3:0] wait_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // Ready only while offered, so a stall really holds the message back
    always @(posedge sys_clk) begin
        if (!rstn) begin
            msg_ready <= 1'b0;
            n_got <= 8'h00;
            wait_cnt <= 4'h0;
        end else if (msg_valid && msg_ready) begin
            msg_ready <= 1'b0;
            n_got <= n_got + 8'h01;
            got_data <= msg_data;
            got_addr <= msg_addr;
            wait_cnt <= 4'h0;
        end else if (msg_valid && wait_cnt >= stall) begin
            msg_ready <= 1'b1;
        end else if (msg_valid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// ### fep_bench.sv
// Self-checking bench for the fault event pending logic
`timescale 1ns/1ps
`include "fep_consts.vh"
module fep_bench;
    logic sys_clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic adv_log_active = 1'b0, rec = 1'b0, aw_t, w_t, ar_t, ok_t;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, rdv;
    logic [3:0] s_axi_wstrb = 4'hF, stall = 4'h0;
    logic [5:0] ev = 6'h00;
    logic [7:0] base;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire msg_valid, msg_ready, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, msg_data, msg_addr, got_data, got_addr;
    wire [7:0] n_got;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    fep_top fep_top_inst (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adv_log_active,
        .rec_valid({4'h0, rec, 2'h0, ev[0]}), .adv_first_evt(ev[1]), .queue_err_evt(ev[2]),
        .cpl_err_evt(ev[3]), .cpl_timeout_evt(ev[4]), .prq_overflow_evt(ev[5]),
        .msg_valid, .msg_ready, .msg_data, .msg_addr, .msg_uaddr(), .irq);
    fep_fabric fep_fabric_inst (.sys_clk, .rstn, .msg_valid, .msg_data, .msg_addr, .stall,
        .msg_ready, .n_got, .got_data, .got_addr);
    initial forever #5 sys_clk = ~sys_clk;
    // Cycle ceiling well above the test length
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus tasks start after a rising edge and sample at the falling edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ok_t = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (ok_t !== 1'b1) begin
            @(negedge sys_clk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            ok_t = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        ok_t = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (ok_t !== 1'b1) begin
            @(negedge sys_clk);
            ar_t = s_axi_arvalid && s_axi_arready;
            ok_t = s_axi_rvalid;
            rdv = s_axi_rdata;
            @(posedge sys_clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
        chk(nm, e, rdv);
    endtask
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge sys_clk);
        ev <= 6'h00;
        @(posedge sys_clk);
    endtask
    task automatic wmsg(input logic [7:0] n);
        while (n_got !== n) @(posedge sys_clk);
    endtask
    task automatic ichk(input logic e);
        @(negedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge sys_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rc("ctl", `FEP_OFF_CTL, 32'h80000000);
        rc("unmapped", 12'h100, 32'h00000000);
        wr(12'h100, 32'h1);
        chk("bresp", {30'h0, `FEP_RESP_SLVERR}, {30'h0, resp});
        $display("test reset done");
        // Masked condition held until unmasked
        wr(`FEP_OFF_DATA, 32'hA5A50001);
        wr(`FEP_OFF_ADDR, 32'hFEE00003);
        pulse(6'h04);
        repeat (4) @(posedge sys_clk);
        chk("held", 32'h0, {24'h0, n_got});
        rc("ctl pend", `FEP_OFF_CTL, 32'hC0000000);
        wr(`FEP_OFF_CTL, 32'h12345678);
        wmsg(8'h01);
        chk("data", 32'hA5A50001, got_data);
        chk("addr", 32'hFEE00000, got_addr);
        rc("ctl sent", `FEP_OFF_CTL, 32'h12345678);
        $display("test mask done");
        // Every source in turn, both logging modes
        for (int k = 0; k < 6; k++) begin
            adv_log_active <= (k == 1);
            rec <= 1'b1;
            base = n_got;
            pulse(6'h01 << k);
            wmsg(base + 8'h01);
        end
        $display("test sources done");
        stall <= 4'h6;
        base = n_got;
        pulse(6'h04);
        pulse(6'h20);
        wmsg(base + 8'h01);
        repeat (12) @(posedge sys_clk);
        chk("one msg", {24'h0, base + 8'h01}, {24'h0, n_got});
        $display("test single done");
        rc("ppf", `FEP_OFF_STATUS, 32'h000000FA);
        // Software clear drops the held message
        rec <= 1'b0;
        wr(`FEP_OFF_CTL, 32'h80000000);
        wr(`FEP_OFF_STATUS, 32'h000000F8);
        base = n_got;
        pulse(6'h08);
        rc("sts", `FEP_OFF_STATUS, 32'h00000020);
        rc("ctl held", `FEP_OFF_CTL, 32'hC0000000);
        wr(`FEP_OFF_STATUS, 32'h00000020);
        rc("ctl drop", `FEP_OFF_CTL, 32'h80000000);
        wr(`FEP_OFF_CTL, 32'h00000000);
        repeat (6) @(posedge sys_clk);
        chk("no msg", {24'h0, base}, {24'h0, n_got});
        $display("test drop done");
        rc("irq sts", `FEP_OFF_IRQ_STS, 32'h0000007F);
        wr(`FEP_OFF_IRQ_EN, 32'h00000004);
        ichk(1'b1);
        wr(`FEP_OFF_IRQ_EN, 32'h00000000);
        ichk(1'b0);
        wr(`FEP_OFF_IRQ_EN, 32'h0000007F);
        wr(`FEP_OFF_IRQ_STS, 32'h0000007F);
        ichk(1'b0);
        rc("irq clr", `FEP_OFF_IRQ_STS, 32'h00000000);
        $display("test irq done");
        complete_run();
    end
endmodule
bind fep_top fep_chk fep_chk_inst (.sys_clk, .rstn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .msg_valid, .msg_ready, .msg_data, .msg_addr, .irq);
